// ---- dv/ppfs_top_tb.sv ----
// Self-checking bench for the port pin function select block.
`timescale 1ns/10ps
module ppfs_top_tb;
  typedef struct {
    logic rd;
    logic err;
    logic [31:0] data;
  } ppfs_note_t;
  logic core_clk;
  logic rstn;
  logic single_chip_mode;
  logic sc_q;
  logic [9:0] pb_gpio_mode;
  logic [9:0] red_oe;
  logic [9:0] pb_output_en;
  logic [15:0] func_q;
  logic [15:0] dir_q;
  logic [15:0] red_q;
  logic [15:0] func_seen;
  logic [15:0] dir_seen;
  logic [15:0] red_dir;
  ppfs_pkg::ppfs_apb_req_t apb_req;
  ppfs_pkg::ppfs_apb_rsp_t apb_rsp;
  ppfs_pkg::ppfs_route_t pin_route;
  ppfs_note_t notes[$];
  ppfs_note_t note;
  int num_errors = 0;
  int comparisons = 0;
  integer seed;

  ppfs_top #(.REDUCED_PINS(1'b0)) dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req),
    .single_chip_mode(single_chip_mode), .pb_gpio_mode(pb_gpio_mode), .apb_rsp(apb_rsp),
    .pin_route(pin_route), .pb_output_en(pb_output_en), .low_pin_function_reg(func_seen),
    .second_port_direction_reg(dir_seen));
  // The reduced variant shares the bus; only its direction side is watched
  ppfs_top #(.REDUCED_PINS(1'b1)) dut_reduced (.core_clk(core_clk), .rstn(rstn),
    .apb_req(apb_req), .single_chip_mode(single_chip_mode), .pb_gpio_mode(pb_gpio_mode),
    .apb_rsp(), .pin_route(), .pb_output_en(red_oe), .low_pin_function_reg(),
    .second_port_direction_reg(red_dir));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic ppfs_pkg::ppfs_route_t exp_route(input logic [15:0] f, input logic sc);
    ppfs_pkg::ppfs_route_t r;
    r = '0;
    r.timer_clock_in_b = f[15:14] == 2'h1;
    r.chip_select_3_out = f[15:14] == 2'h2 && !sc;
    r.gpio[7] = !(r.timer_clock_in_b || r.chip_select_3_out);
    r.timer_clock_in_a = f[13:12] == 2'h1;
    r.chip_select_2_out = f[13:12] == 2'h2 && !sc;
    r.gpio[6] = !(r.timer_clock_in_a || r.chip_select_2_out);
    r.serial_clock_ch1 = f[11:10] == 2'h1;
    r.dma_request_in_1 = f[11:10] == 2'h2 && !sc;
    r.interrupt_request_in_1 = f[11:10] == 2'h3;
    r.gpio[5] = !(r.serial_clock_ch1 || r.dma_request_in_1 || r.interrupt_request_in_1);
    r.serial_tx_ch1 = f[8];
    r.gpio[4] = !f[8];
    r.serial_rx_ch1 = f[6];
    r.gpio[3] = !f[6];
    r.serial_clock_ch0 = f[5:4] == 2'h1;
    r.dma_request_in_0 = f[5:4] == 2'h2 && !sc;
    r.interrupt_request_in_0 = f[5:4] == 2'h3;
    r.gpio[2] = !(r.serial_clock_ch0 || r.dma_request_in_0 || r.interrupt_request_in_0);
    r.serial_tx_ch0 = f[2];
    r.gpio[1] = !f[2];
    r.serial_rx_ch0 = f[0];
    r.gpio[0] = !f[0];
    return r;
  endfunction

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    ppfs_note_t n;
    int i;
    logic lo;
    lo = addr == ppfs_pkg::OFS_LOW_FUNC;
    n.rd = !wr;
    n.err = !(lo || addr == ppfs_pkg::OFS_PB_DIR);
    n.data = n.err ? 32'h0 : {16'h0, lo ? func_q : dir_q};
    notes.push_back(n);
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (apb_rsp.pready !== 1'b1 && i < 50);
    if (i == 50) begin
      check(32'h1, 32'h0);
    end
    if (wr && !n.err && lo) begin
      func_q = wd[15:0] & 16'hfd75;
    end else if (wr && !n.err) begin
      dir_q = wd[15:0] & 16'h03ff;
      red_q = wd[15:0] & 16'h03fc;
    end
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    #1;
  endtask

  task automatic check_pins();
    check(32'(pin_route), 32'(exp_route(func_q, sc_q)));
    check({22'h0, pb_output_en}, {22'h0, dir_q[9:0] & pb_gpio_mode});
    check({22'h0, red_oe}, {22'h0, red_q[9:0] & pb_gpio_mode});
    check({func_seen, dir_seen}, {func_q, dir_q});
    check({16'h0, red_dir}, {16'h0, red_q});
  endtask

  // Response monitor: every completed transfer consumes the oldest note
  always @(posedge core_clk) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        note = notes.pop_front();
        check({31'h0, apb_rsp.pslverr}, {31'h0, note.err});
        if (note.rd) begin
          check(apb_rsp.prdata, note.data);
        end
      end
    end
  end

  initial begin
    #50us;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    apb_req = '0;
    rstn = 1'b0;
    single_chip_mode = 1'b0;
    sc_q = 1'b0;
    pb_gpio_mode = '0;
    func_q = '0;
    dir_q = '0;
    red_q = '0;
    seed = 32'he9f5fe69;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    check_pins();
    apb(1'b0, ppfs_pkg::OFS_LOW_FUNC, 32'h0);
    apb(1'b0, ppfs_pkg::OFS_PB_DIR, 32'h0);
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      single_chip_mode <= m[0];
      sc_q = m[0];
      repeat (4) @(posedge core_clk);
      #1;
      check_pins();
      // Every route code on every field, reserved bits written as ones
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, ppfs_pkg::OFS_LOW_FUNC, {16'($random(seed)), {3{c[1:0]}}, 1'b1, c[0],
          1'b1, c[0], c[1:0], 1'b1, c[0], 1'b1, c[0]});
        check_pins();
        apb(1'b0, ppfs_pkg::OFS_LOW_FUNC, 32'h0);
      end
      for (int i = 0; i < 20; i++) begin
        @(posedge core_clk);
        pb_gpio_mode <= 10'($random(seed));
        apb(1'b1, ($random(seed) & 1) ? ppfs_pkg::OFS_LOW_FUNC : ppfs_pkg::OFS_PB_DIR,
          $random(seed));
        check_pins();
        apb(1'b0, ppfs_pkg::OFS_PB_DIR, 32'h0);
      end
    end
    // Unmapped places are refused and leave the registers alone
    apb(1'b1, 12'h008, 32'hffff_ffff);
    apb(1'b1, 12'h002, 32'hffff_ffff);
    apb(1'b0, 12'hffc, 32'h0);
    check_pins();
    // Second power-on reset in mid-run clears both registers
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    func_q = '0;
    dir_q = '0;
    red_q = '0;
    repeat (4) @(posedge core_clk);
    #1;
    check_pins();
    apb(1'b0, ppfs_pkg::OFS_PB_DIR, 32'h0);
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule

// ---- hw/ppfs_pkg.sv ----
// Package for the port pin function select block: register map, fields, carriers.
package ppfs_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned LOW_PINS = 8;
  localparam int unsigned PB_PINS = 10;

  // Byte addresses of the two registers on APB
  localparam logic [ADDR_W-1:0] OFS_LOW_FUNC = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PB_DIR = 12'h004;

  // Reset values, taken on external power-on reset only
  localparam logic [REG_W-1:0] LOW_FUNC_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PB_DIR_RESET = 16'h0000;

  // Bits that hold state; every other bit reads as zero
  localparam logic [REG_W-1:0] LOW_FUNC_WMASK = 16'hfd75;
  localparam logic [REG_W-1:0] PB_DIR_WMASK = 16'h03ff;
  localparam logic [REG_W-1:0] PB_DIR_REDUCED_WMASK = 16'h03fc;

  // Field positions in the low function register
  localparam int unsigned PIN7_LSB = 14;
  localparam int unsigned PIN6_LSB = 12;
  localparam int unsigned PIN5_LSB = 10;
  localparam int unsigned PIN4_BIT = 8;
  localparam int unsigned PIN3_BIT = 6;
  localparam int unsigned PIN2_LSB = 4;
  localparam int unsigned PIN1_BIT = 2;
  localparam int unsigned PIN0_BIT = 0;

  // Two-bit route codes
  typedef enum logic [1:0] {
    PPFS_CODE_GPIO = 2'h0,
    PPFS_CODE_ALT1 = 2'h1,
    PPFS_CODE_ALT2 = 2'h2,
    PPFS_CODE_ALT3 = 2'h3
  } ppfs_code_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ppfs_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } ppfs_apb_rsp_t;

  // One select per pin function; gpio[n] means low pin n is general I/O
  typedef struct packed {
    logic [LOW_PINS-1:0] gpio;
    logic timer_clock_in_b;
    logic timer_clock_in_a;
    logic chip_select_3_out;
    logic chip_select_2_out;
    logic serial_clock_ch1;
    logic dma_request_in_1;
    logic interrupt_request_in_1;
    logic serial_tx_ch1;
    logic serial_rx_ch1;
    logic serial_clock_ch0;
    logic dma_request_in_0;
    logic interrupt_request_in_0;
    logic serial_tx_ch0;
    logic serial_rx_ch0;
  } ppfs_route_t;

endpackage

// ---- hw/ppfs_route.sv ----
// Decoder from the low function register and the operating mode to pin routes.
`timescale 1ns/10ps
module ppfs_route (
  input wire logic [ppfs_pkg::REG_W-1:0] func,
  input wire logic single_chip,
  output ppfs_pkg::ppfs_route_t route
);

  function automatic ppfs_pkg::ppfs_code_t field2(
    input logic [ppfs_pkg::REG_W-1:0] f,
    input int unsigned lsb
  );
    field2 = ppfs_pkg::ppfs_code_t'(f[lsb +: 2]);
  endfunction

  ppfs_pkg::ppfs_code_t code7;
  ppfs_pkg::ppfs_code_t code6;
  ppfs_pkg::ppfs_code_t code5;
  ppfs_pkg::ppfs_code_t code2;

  assign code7 = field2(func, ppfs_pkg::PIN7_LSB);
  assign code6 = field2(func, ppfs_pkg::PIN6_LSB);
  assign code5 = field2(func, ppfs_pkg::PIN5_LSB);
  assign code2 = field2(func, ppfs_pkg::PIN2_LSB);

  // Bus-side functions fall back to general I/O in single-chip mode;
  // reserved codes also land on general I/O so a pin is never left floating
  always_comb begin
    route = '0;
    case (code7)
      ppfs_pkg::PPFS_CODE_ALT1: route.timer_clock_in_b = 1'b1;
      ppfs_pkg::PPFS_CODE_ALT2: begin
        route.chip_select_3_out = !single_chip;
        route.gpio[7] = single_chip;
      end
      default: route.gpio[7] = 1'b1;
    endcase
    case (code6)
      ppfs_pkg::PPFS_CODE_ALT1: route.timer_clock_in_a = 1'b1;
      ppfs_pkg::PPFS_CODE_ALT2: begin
        route.chip_select_2_out = !single_chip;
        route.gpio[6] = single_chip;
      end
      default: route.gpio[6] = 1'b1;
    endcase
    case (code5)
      ppfs_pkg::PPFS_CODE_ALT1: route.serial_clock_ch1 = 1'b1;
      ppfs_pkg::PPFS_CODE_ALT2: begin
        route.dma_request_in_1 = !single_chip;
        route.gpio[5] = single_chip;
      end
      ppfs_pkg::PPFS_CODE_ALT3: route.interrupt_request_in_1 = 1'b1;
      default: route.gpio[5] = 1'b1;
    endcase
    route.serial_tx_ch1 = func[ppfs_pkg::PIN4_BIT];
    route.gpio[4] = !func[ppfs_pkg::PIN4_BIT];
    route.serial_rx_ch1 = func[ppfs_pkg::PIN3_BIT];
    route.gpio[3] = !func[ppfs_pkg::PIN3_BIT];
    case (code2)
      ppfs_pkg::PPFS_CODE_ALT1: route.serial_clock_ch0 = 1'b1;
      ppfs_pkg::PPFS_CODE_ALT2: begin
        route.dma_request_in_0 = !single_chip;
        route.gpio[2] = single_chip;
      end
      ppfs_pkg::PPFS_CODE_ALT3: route.interrupt_request_in_0 = 1'b1;
      default: route.gpio[2] = 1'b1;
    endcase
    route.serial_tx_ch0 = func[ppfs_pkg::PIN1_BIT];
    route.gpio[1] = !func[ppfs_pkg::PIN1_BIT];
    route.serial_rx_ch0 = func[ppfs_pkg::PIN0_BIT];
    route.gpio[0] = !func[ppfs_pkg::PIN0_BIT];
  end

endmodule

// ---- hw/ppfs_top.sv ----
// Port pin function select: APB registers, low-pin routing and second-port direction.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module ppfs_top #(
  parameter bit REDUCED_PINS = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input ppfs_pkg::ppfs_apb_req_t apb_req,
  input wire logic single_chip_mode,
  input wire logic [ppfs_pkg::PB_PINS-1:0] pb_gpio_mode,
  output ppfs_pkg::ppfs_apb_rsp_t apb_rsp,
  output ppfs_pkg::ppfs_route_t pin_route,
  output logic [ppfs_pkg::PB_PINS-1:0] pb_output_en,
  output logic [ppfs_pkg::REG_W-1:0] low_pin_function_reg,
  output logic [ppfs_pkg::REG_W-1:0] second_port_direction_reg
);

  localparam logic [ppfs_pkg::REG_W-1:0] DIR_MASK =
    REDUCED_PINS ? ppfs_pkg::PB_DIR_REDUCED_WMASK : ppfs_pkg::PB_DIR_WMASK;
  localparam int unsigned PAD_W = ppfs_pkg::DATA_W - ppfs_pkg::REG_W;

  function automatic logic hit(
    input logic [ppfs_pkg::ADDR_W-1:0] a,
    input logic [ppfs_pkg::ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  logic sc_meta;
  logic sc_sync;
  logic access;
  logic done;
  logic wr_low;
  logic wr_dir;
  logic mapped;
  logic [ppfs_pkg::REG_W-1:0] next_low_func;
  logic [ppfs_pkg::REG_W-1:0] next_dir;
  logic [ppfs_pkg::REG_W-1:0] rd_word;
  ppfs_pkg::ppfs_route_t next_route;

  // The mode strap comes from a pin, so it is synchronised first
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sc_meta <= 1'b0;
      sc_sync <= 1'b0;
    end else begin
      sc_meta <= single_chip_mode;
      sc_sync <= sc_meta;
    end
  end

  // One wait state: pready is a flop, so the slave cannot answer in the first access cycle
  assign access = apb_req.psel && apb_req.penable;
  assign done = access && apb_rsp.pready;
  assign mapped = hit(apb_req.paddr, ppfs_pkg::OFS_LOW_FUNC) ||
                  hit(apb_req.paddr, ppfs_pkg::OFS_PB_DIR);
  assign wr_low = done && apb_req.pwrite && hit(apb_req.paddr, ppfs_pkg::OFS_LOW_FUNC);
  assign wr_dir = done && apb_req.pwrite && hit(apb_req.paddr, ppfs_pkg::OFS_PB_DIR);

  // Only writable bits are stored, so reserved bits can never read back as one
  always_comb begin
    next_low_func = low_pin_function_reg;
    next_dir = second_port_direction_reg;
    if (wr_low) begin
      next_low_func = apb_req.pwdata[ppfs_pkg::REG_W-1:0] & ppfs_pkg::LOW_FUNC_WMASK;
    end
    if (wr_dir) begin
      next_dir = apb_req.pwdata[ppfs_pkg::REG_W-1:0] & DIR_MASK;
    end
  end

  always_comb begin
    rd_word = '0;
    if (hit(apb_req.paddr, ppfs_pkg::OFS_LOW_FUNC)) begin
      rd_word = low_pin_function_reg;
    end else if (hit(apb_req.paddr, ppfs_pkg::OFS_PB_DIR)) begin
      rd_word = second_port_direction_reg;
    end
  end

  // Watchdog, standby and sleep are deliberately not inputs here:
  // only the power-on reset may clear the configuration
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_pin_function_reg <= ppfs_pkg::LOW_FUNC_RESET;
    end else begin
      low_pin_function_reg <= next_low_func;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      second_port_direction_reg <= ppfs_pkg::PB_DIR_RESET;
    end else begin
      second_port_direction_reg <= next_dir;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= access && !apb_rsp.pready;
      apb_rsp.pslverr <= access && !apb_rsp.pready && !mapped;
      if (access && !apb_rsp.pready && !apb_req.pwrite) begin
        apb_rsp.prdata <= {{PAD_W{1'b0}}, rd_word};
      end else begin
        apb_rsp.prdata <= '0;
      end
    end
  end

  ppfs_route u_route (
    .func(next_low_func),
    .single_chip(sc_sync),
    .route(next_route)
  );

  // Routes are fed from next values so a write shows on the pins at its own edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_route <= '0;
      pin_route.gpio <= '1;
    end else begin
      pin_route <= next_route;
    end
  end

  // A direction bit only drives while the pin is general I/O
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pb_output_en <= '0;
    end else begin
      pb_output_en <= next_dir[ppfs_pkg::PB_PINS-1:0] & pb_gpio_mode;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_low_reserved_zero;
    (low_pin_function_reg & ~ppfs_pkg::LOW_FUNC_WMASK) == '0;
  endproperty
  a_low_reserved_zero: assert property (p_low_reserved_zero)
    else $error("Reserved function bits not zero");

  property p_dir_upper_zero;
    (second_port_direction_reg & ~DIR_MASK) == '0;
  endproperty
  a_dir_upper_zero: assert property (p_dir_upper_zero)
    else $error("Unused direction bits not zero");

  property p_pin7_cs3;
    (low_pin_function_reg[ppfs_pkg::PIN7_LSB +: 2] == 2'h2 && !$past(sc_sync))
      |-> (pin_route.chip_select_3_out && !pin_route.gpio[7]);
  endproperty
  a_pin7_cs3: assert property (p_pin7_cs3)
    else $error("Pin 7 chip select not routed");

  property p_pin6_timer;
    low_pin_function_reg[ppfs_pkg::PIN6_LSB +: 2] == 2'h1
      |-> (pin_route.timer_clock_in_a && !pin_route.gpio[6] && !pin_route.chip_select_2_out);
  endproperty
  a_pin6_timer: assert property (p_pin6_timer)
    else $error("Pin 6 timer clock not routed");

  property p_pin5_irq;
    low_pin_function_reg[ppfs_pkg::PIN5_LSB +: 2] == 2'h3
      |-> (pin_route.interrupt_request_in_1 && !pin_route.gpio[5]);
  endproperty
  a_pin5_irq: assert property (p_pin5_irq)
    else $error("Pin 5 interrupt request not routed");

  property p_serial_bits;
    pin_route.serial_tx_ch1 == low_pin_function_reg[ppfs_pkg::PIN4_BIT] &&
    pin_route.serial_rx_ch1 == low_pin_function_reg[ppfs_pkg::PIN3_BIT] &&
    pin_route.serial_tx_ch0 == low_pin_function_reg[ppfs_pkg::PIN1_BIT] &&
    pin_route.serial_rx_ch0 == low_pin_function_reg[ppfs_pkg::PIN0_BIT];
  endproperty
  a_serial_bits: assert property (p_serial_bits)
    else $error("Serial data route does not follow its bit");

  property p_pin2_serial_clock_ch0;
    low_pin_function_reg[ppfs_pkg::PIN2_LSB +: 2] == 2'h1
      |-> (pin_route.serial_clock_ch0 && !pin_route.dma_request_in_0 && !pin_route.gpio[2]);
  endproperty
  a_pin2_serial_clock_ch0: assert property (p_pin2_serial_clock_ch0)
    else $error("Pin 2 serial clock not routed");

  property p_single_chip_gpio;
    ($past(sc_sync) && low_pin_function_reg[ppfs_pkg::PIN2_LSB +: 2] == 2'h2)
      |-> (pin_route.gpio[2] && !pin_route.dma_request_in_0);
  endproperty
  a_single_chip_gpio: assert property (p_single_chip_gpio)
    else $error("DMA request active in single-chip mode");

  property p_dir_gated;
    ##1 pb_output_en ==
      (second_port_direction_reg[ppfs_pkg::PB_PINS-1:0] & $past(pb_gpio_mode));
  endproperty
  a_dir_gated: assert property (p_dir_gated)
    else $error("Output enable does not follow direction and mode");

  property p_hold_without_write;
    !(done && apb_req.pwrite)
      |=> ($stable(low_pin_function_reg) && $stable(second_port_direction_reg));
  endproperty
  a_hold_without_write: assert property (p_hold_without_write)
    else $error("Configuration changed without a write");

  property p_write_same_edge;
    wr_low |=> (low_pin_function_reg ==
                ($past(apb_req.pwdata[ppfs_pkg::REG_W-1:0]) & ppfs_pkg::LOW_FUNC_WMASK)) &&
               (pin_route.serial_rx_ch0 == low_pin_function_reg[ppfs_pkg::PIN0_BIT]);
  endproperty
  a_write_same_edge: assert property (p_write_same_edge)
    else $error("Write did not reach routes at its edge");

  property p_reserved_gpio;
    low_pin_function_reg[ppfs_pkg::PIN7_LSB +: 2] == 2'h3
      |-> (pin_route.gpio[7] && !pin_route.timer_clock_in_b && !pin_route.chip_select_3_out);
  endproperty
  a_reserved_gpio: assert property (p_reserved_gpio)
    else $error("Reserved code did not leave pin as general I/O");

  property p_one_wait;
    (access && !apb_rsp.pready) |=> (apb_rsp.pready ##1 !apb_rsp.pready);
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("APB answer not after exactly one wait");

  property p_slverr_unmapped;
    (access && !apb_rsp.pready && !mapped) |=> (apb_rsp.pslverr && apb_rsp.prdata == '0);
  endproperty
  a_slverr_unmapped: assert property (p_slverr_unmapped)
    else $error("Unmapped access not flagged");

  property p_pin7_timer;
    low_pin_function_reg[ppfs_pkg::PIN7_LSB +: 2] == ppfs_pkg::PPFS_CODE_ALT1
      |-> (pin_route.timer_clock_in_b && !pin_route.gpio[7] && !pin_route.chip_select_3_out);
  endproperty
  a_pin7_timer: assert property (p_pin7_timer)
    else $error("Pin 7 timer clock not routed");

  property p_pin6_cs2;
    (low_pin_function_reg[ppfs_pkg::PIN6_LSB +: 2] == ppfs_pkg::PPFS_CODE_ALT2 && !$past(sc_sync))
      |-> (pin_route.chip_select_2_out && !pin_route.gpio[6]);
  endproperty
  a_pin6_cs2: assert property (p_pin6_cs2)
    else $error("Pin 6 chip select not routed");

  property p_pin6_reserved;
    low_pin_function_reg[ppfs_pkg::PIN6_LSB +: 2] == ppfs_pkg::PPFS_CODE_ALT3
      |-> (pin_route.gpio[6] && !pin_route.timer_clock_in_a && !pin_route.chip_select_2_out);
  endproperty
  a_pin6_reserved: assert property (p_pin6_reserved)
    else $error("Pin 6 reserved code did not leave general I/O");

  property p_pin5_dma;
    (low_pin_function_reg[ppfs_pkg::PIN5_LSB +: 2] == ppfs_pkg::PPFS_CODE_ALT2 && !$past(sc_sync))
      |-> (pin_route.dma_request_in_1 && !pin_route.gpio[5]);
  endproperty
  a_pin5_dma: assert property (p_pin5_dma)
    else $error("Pin 5 DMA request not routed");

  property p_pin2_irq;
    low_pin_function_reg[ppfs_pkg::PIN2_LSB +: 2] == ppfs_pkg::PPFS_CODE_ALT3
      |-> (pin_route.interrupt_request_in_0 && !pin_route.gpio[2] && !pin_route.serial_clock_ch0);
  endproperty
  a_pin2_irq: assert property (p_pin2_irq)
    else $error("Pin 2 interrupt request not routed");

  // Bus-side selects must never leak out while the part runs without an external bus
  property p_single_chip_no_bus;
    $past(sc_sync) |-> (!pin_route.chip_select_3_out && !pin_route.chip_select_2_out &&
                        !pin_route.dma_request_in_1 && !pin_route.dma_request_in_0);
  endproperty
  a_single_chip_no_bus: assert property (p_single_chip_no_bus)
    else $error("Bus function selected in single-chip mode");

  // Two functions on one pin would short a driver against an input
  property p_one_function;
    $onehot({pin_route.gpio[7], pin_route.timer_clock_in_b, pin_route.chip_select_3_out}) &&
    $onehot({pin_route.gpio[6], pin_route.timer_clock_in_a, pin_route.chip_select_2_out}) &&
    $onehot({pin_route.gpio[5], pin_route.serial_clock_ch1, pin_route.dma_request_in_1,
             pin_route.interrupt_request_in_1}) &&
    $onehot({pin_route.gpio[2], pin_route.serial_clock_ch0, pin_route.dma_request_in_0,
             pin_route.interrupt_request_in_0});
  endproperty
  a_one_function: assert property (p_one_function)
    else $error("Low pin has not exactly one function");

  property p_write_dir_edge;
    wr_dir |=> (second_port_direction_reg ==
                ($past(apb_req.pwdata[ppfs_pkg::REG_W-1:0]) & DIR_MASK)) &&
               (pb_output_en ==
                (second_port_direction_reg[ppfs_pkg::PB_PINS-1:0] & $past(pb_gpio_mode)));
  endproperty
  a_write_dir_edge: assert property (p_write_dir_edge)
    else $error("Direction write did not reach pins at its edge");

  property p_reduced_no_pins;
    REDUCED_PINS |->
      ((second_port_direction_reg & ~ppfs_pkg::PB_DIR_REDUCED_WMASK) == '0) &&
      ((pb_output_en & ~ppfs_pkg::PB_DIR_REDUCED_WMASK[ppfs_pkg::PB_PINS-1:0]) == '0);
  endproperty
  a_reduced_no_pins: assert property (p_reduced_no_pins)
    else $error("Missing pins of reduced variant not zero");

endmodule
